//--- power_mode_pkg.sv
package power_mode_pkg;
    // register offsets (byte addresses on the plain register port)
    localparam logic [23:0] MODE_CTRL_ADDR = 24'hFFFC60;
    localparam logic [23:0] CLK_STAT_ADDR = 24'hFFFC62;
    // control register field positions
    localparam int SAVE_BIT = 0;
    localparam int IDLE_BIT = 1;
    localparam int HALT_BIT = 2;
    localparam int WAIT_BEFORE_BIT = 3;
    localparam int OSC_DIS_BIT = 4;
    localparam int PLL_DIS_BIT = 5;
    localparam int OSC_GATE_BIT = 6;
    localparam int PLL_GATE_BIT = 7;
    // status register field positions
    localparam int LOW_STABLE_BIT = 0;
    localparam int MAIN_STABLE_BIT = 1;
    localparam int PLL_STABLE_BIT = 2;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;
    // synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 2;
    // power modes
    typedef enum logic [1:0] {
        MODE_ACTIVE,
        MODE_SAVE,
        MODE_IDLE,
        MODE_HALT
    } power_mode_t;
    // sequencer states
    typedef enum logic [2:0] {
        SEQ_RUN,
        SEQ_ENTER_SAVE,
        SEQ_WAKE_OSC,
        SEQ_WAKE_PLL,
        SEQ_LEAVE_SAVE
    } seq_state_t;
endpackage : power_mode_pkg

//--- pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for a group of pin inputs
module pin_sync
    import power_mode_pkg::*;
#(
    parameter int WIDTH = 4
)
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [WIDTH-1:0] D,
    output logic [WIDTH-1:0] Q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta_r; // first stage, read only by second stage
        logic [WIDTH-1:0] sync_r; // second stage, safe to use
    } sync_state_t;
    sync_state_t s_r;
    sync_state_t s_nxt;

    // shift the pins through both stages
    always_comb
    begin
        s_nxt.meta_r = D;
        s_nxt.sync_r = s_r.meta_r;
    end

    // reset to zero: stable flags look absent until proven
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign Q = s_r.sync_r;
endmodule : pin_sync
`default_nettype wire

//--- power_mode_manager.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module power_mode_manager
    import power_mode_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [23:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic WAIT_EXEC,
    input wire logic WAKE,
    input wire logic LINK_SLEEP,
    input wire logic PLL_POWER_DOWN,
    input wire logic MAIN_OSC_STABLE,
    input wire logic PLL_STABLE,
    input wire logic LOW_OSC_STABLE,
    output logic SYS_CLK_EN,
    output logic SYS_CLK_SLOW,
    output logic SLOW_CLK_EN,
    output logic MAIN_OSC_EN,
    output logic PLL_EN,
    output logic AUX_CLK_EN,
    output logic LOW_OSC_LOWPOWER,
    output logic [1:0] POWER_MODE
);
    // all state of the manager
    typedef struct packed {
        power_mode_t mode_r;     // current power mode
        seq_state_t seq_r;       // transition sequencer
        logic [7:0] ctrl_r;      // control register image
        logic armed_r;           // request waiting for a wait instruction
        logic [7:0] rdata_r;     // read data
        logic sys_en_r;          // system clock gate
        logic sys_slow_r;        // system clock from slow clock
        logic slow_en_r;         // slow clock gate
        logic osc_en_r;          // main oscillator enable
        logic pll_en_r;          // pll enable
    } pm_state_t;
    pm_state_t s_r;
    pm_state_t s_nxt;

    logic [2:0] stab; // synchronised stable flags: pll, main, low
    logic [1:0] evt;  // synchronised wake and link sleep
    logic wake_now;
    logic sleep_now;

    // analog stable flags and wake pins come from other clocks
    pin_sync #(.WIDTH(5)) pin_sync_inst (
        .CLK(CLK),
        .RST_N(RST_N),
        .D({PLL_STABLE, MAIN_OSC_STABLE, LOW_OSC_STABLE, WAKE, LINK_SLEEP}),
        .Q({stab, evt})
    );
    assign wake_now = evt[1];
    assign sleep_now = evt[0];

    // next-state logic
    always_comb
    begin
        logic wr_ctrl;
        logic in_low;
        logic osc_off;
        logic pll_off;
        logic pll_ok;
        logic waking;   // wake sequence owns the sources
        logic halt_lag; // first cycle of halt
        wr_ctrl = 1'b0;
        in_low = 1'b0;
        osc_off = 1'b0;
        pll_off = 1'b0;
        pll_ok = 1'b0;
        waking = 1'b0;
        halt_lag = 1'b0;
        s_nxt = s_r;
        wr_ctrl = WR && (ADDR == MODE_CTRL_ADDR);
        // pll stable reads set while pll is disabled
        pll_ok = stab[2] || !s_r.pll_en_r;

        // read path: data one cycle after the strobe, unmapped reads zero
        s_nxt.rdata_r = READ_IDLE;
        if (RD && ADDR == MODE_CTRL_ADDR)
        begin
            s_nxt.rdata_r = s_r.ctrl_r;
        end
        else if (RD && ADDR == CLK_STAT_ADDR)
        begin
            s_nxt.rdata_r = {5'h00, pll_ok, stab[1], stab[0]};
        end

        // software writes: mode bits are request bits, handled below
        if (wr_ctrl)
        begin
            s_nxt.ctrl_r[7:3] = WDATA[7:3];
            s_nxt.ctrl_r[IDLE_BIT] = WDATA[IDLE_BIT];
            s_nxt.ctrl_r[HALT_BIT] = WDATA[HALT_BIT];
            if (WDATA[SAVE_BIT] && !s_r.ctrl_r[SAVE_BIT])
            begin
                if (WDATA[WAIT_BEFORE_BIT])
                begin
                    // deferred entry: bit reads one at once
                    s_nxt.ctrl_r[SAVE_BIT] = 1'b1;
                end
                else if (s_r.mode_r == MODE_ACTIVE && s_r.seq_r == SEQ_RUN)
                begin
                    s_nxt.seq_r = SEQ_ENTER_SAVE;
                end
            end
            else if (!WDATA[SAVE_BIT] && s_r.ctrl_r[SAVE_BIT])
            begin
                if (s_r.mode_r == MODE_SAVE && s_r.seq_r == SEQ_RUN)
                begin
                    // bit stays set until active is reached
                    s_nxt.seq_r = SEQ_LEAVE_SAVE;
                end
                else if (s_r.mode_r == MODE_ACTIVE)
                begin
                    s_nxt.ctrl_r[SAVE_BIT] = 1'b0;
                end
            end
            // requests armed only with wait-before set
            s_nxt.armed_r = WDATA[WAIT_BEFORE_BIT] &&
                (WDATA[SAVE_BIT] || WDATA[IDLE_BIT] || WDATA[HALT_BIT]);
        end

        // sequencer
        unique case (s_r.seq_r)
            SEQ_RUN:
            begin
                if (wake_now && s_r.mode_r != MODE_ACTIVE)
                begin
                    // wake: re-enable the oscillator first
                    s_nxt.ctrl_r[OSC_DIS_BIT] = 1'b0;
                    s_nxt.seq_r = SEQ_WAKE_OSC;
                end
                else if (WAIT_EXEC && s_r.armed_r && s_r.mode_r != MODE_HALT && stab[0])
                begin
                    // low oscillator must be stable before leaving active
                    s_nxt.armed_r = 1'b0;
                    if (s_r.ctrl_r[HALT_BIT])
                    begin
                        s_nxt.mode_r = MODE_HALT;
                    end
                    else if (s_r.ctrl_r[IDLE_BIT])
                    begin
                        s_nxt.mode_r = MODE_IDLE;
                    end
                    else if (s_r.ctrl_r[SAVE_BIT])
                    begin
                        s_nxt.mode_r = MODE_SAVE;
                    end
                end
            end
            SEQ_ENTER_SAVE:
            begin
                // waits on the low oscillator before switching
                if (stab[0])
                begin
                    s_nxt.mode_r = MODE_SAVE;
                    s_nxt.ctrl_r[SAVE_BIT] = 1'b1;
                    s_nxt.seq_r = SEQ_RUN;
                end
            end
            SEQ_WAKE_OSC:
            begin
                s_nxt.ctrl_r[OSC_DIS_BIT] = 1'b0;
                if (stab[1])
                begin
                    s_nxt.ctrl_r[PLL_DIS_BIT] = 1'b0;
                    s_nxt.ctrl_r[HALT_BIT] = 1'b0;
                    s_nxt.seq_r = SEQ_WAKE_PLL;
                end
            end
            SEQ_WAKE_PLL:
            begin
                s_nxt.ctrl_r[PLL_DIS_BIT] = 1'b0;
                if (pll_ok)
                begin
                    s_nxt.mode_r = MODE_ACTIVE;
                    s_nxt.ctrl_r[SAVE_BIT] = 1'b0;
                    s_nxt.ctrl_r[IDLE_BIT] = 1'b0;
                    s_nxt.armed_r = 1'b0;
                    s_nxt.seq_r = SEQ_RUN;
                end
            end
            SEQ_LEAVE_SAVE:
            begin
                // active needs the main oscillator and pll stable
                if (stab[1] && pll_ok)
                begin
                    s_nxt.mode_r = MODE_ACTIVE;
                    s_nxt.ctrl_r[SAVE_BIT] = 1'b0;
                    s_nxt.seq_r = SEQ_RUN;
                end
            end
            default:
            begin
                s_nxt.seq_r = SEQ_RUN;
            end
        endcase

        // gating bits are dropped whenever active mode is reached
        if (s_nxt.mode_r == MODE_ACTIVE && s_r.mode_r != MODE_ACTIVE)
        begin
            s_nxt.ctrl_r[OSC_GATE_BIT] = 1'b0;
            s_nxt.ctrl_r[PLL_GATE_BIT] = 1'b0;
        end

        // clock decisions use the mode actually entered, so disables act after entry
        in_low = (s_nxt.mode_r == MODE_SAVE) || (s_nxt.mode_r == MODE_IDLE);
        // disable bit wins; gating only with link asleep and disable clear
        osc_off = in_low && (s_nxt.ctrl_r[OSC_DIS_BIT] ||
            (s_nxt.ctrl_r[OSC_GATE_BIT] && sleep_now));
        pll_off = in_low && (s_nxt.ctrl_r[PLL_DIS_BIT] ||
            (s_nxt.ctrl_r[PLL_GATE_BIT] && sleep_now && !PLL_POWER_DOWN));
        // a wake needs the oscillator, then the pll, even from halt or a gated
        // sleep; without this the sequencer would wait forever on a stable flag
        waking = (s_nxt.seq_r == SEQ_WAKE_OSC) || (s_nxt.seq_r == SEQ_WAKE_PLL);
        // on halt entry the sources outlive the system clock by one cycle
        halt_lag = (s_nxt.mode_r == MODE_HALT) && (s_r.mode_r != MODE_HALT);
        // active forces on (the pll only without power-down), halt forces off once the system clock has stopped,
        // except the oscillator while a wake runs and the pll in SEQ_WAKE_PLL
        s_nxt.osc_en_r = (s_nxt.mode_r == MODE_ACTIVE) || waking ||
            (halt_lag && s_r.osc_en_r) ||
            (in_low && !osc_off);
        s_nxt.pll_en_r = !PLL_POWER_DOWN && ((s_nxt.mode_r == MODE_ACTIVE) ||
            (s_nxt.seq_r == SEQ_WAKE_PLL) || (halt_lag && s_r.pll_en_r) ||
            (in_low && !pll_off));
        // system clock stops in idle and halt; slow domain stops only in halt
        s_nxt.sys_en_r = (s_nxt.mode_r == MODE_ACTIVE) ||
            (s_nxt.mode_r == MODE_SAVE);
        s_nxt.sys_slow_r = (s_nxt.mode_r == MODE_SAVE);
        s_nxt.slow_en_r = (s_nxt.mode_r != MODE_HALT);
    end

    // register the whole state
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            s_r.mode_r <= MODE_ACTIVE;
            s_r.seq_r <= SEQ_RUN;
            s_r.ctrl_r <= CTRL_RESET;
            s_r.armed_r <= 1'b0;
            s_r.rdata_r <= READ_IDLE;
            s_r.sys_en_r <= 1'b1;
            s_r.sys_slow_r <= 1'b0;
            s_r.slow_en_r <= 1'b1;
            s_r.osc_en_r <= 1'b1;
            s_r.pll_en_r <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // outputs
    assign RDATA = s_r.rdata_r;
    assign SYS_CLK_EN = s_r.sys_en_r;
    assign SYS_CLK_SLOW = s_r.sys_slow_r;
    assign SLOW_CLK_EN = s_r.slow_en_r;
    assign MAIN_OSC_EN = s_r.osc_en_r;
    assign PLL_EN = s_r.pll_en_r;
    // aux clocks follow the main oscillator
    assign AUX_CLK_EN = s_r.osc_en_r;
    assign LOW_OSC_LOWPOWER = (s_r.mode_r == MODE_HALT);
    assign POWER_MODE = s_r.mode_r;

    // checks
    halt_clocks_a: assert property (@(posedge CLK) disable iff (!RST_N)
        LOW_OSC_LOWPOWER && $past(LOW_OSC_LOWPOWER) && s_r.seq_r == SEQ_RUN
        |-> !MAIN_OSC_EN && !PLL_EN && !SLOW_CLK_EN)
        else $error("halt left a clock running");
    idle_sysclk_a: assert property (@(posedge CLK) disable iff (!RST_N)
        s_r.mode_r == MODE_IDLE |-> !SYS_CLK_EN && SLOW_CLK_EN)
        else $error("idle clock gating wrong");
    active_on_a: assert property (@(posedge CLK) disable iff (!RST_N)
        s_r.mode_r == MODE_ACTIVE |-> MAIN_OSC_EN && (PLL_EN == !$past(PLL_POWER_DOWN)))
        else $error("active mode clocks not on");
    aux_follow_a: assert property (@(posedge CLK) disable iff (!RST_N)
        AUX_CLK_EN |-> MAIN_OSC_EN)
        else $error("aux clock without main clock");
    osc_dis_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (s_r.mode_r == MODE_SAVE || s_r.mode_r == MODE_IDLE) && s_r.ctrl_r[OSC_DIS_BIT]
        |-> !MAIN_OSC_EN)
        else $error("oscillator not disabled");
    gate_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
        $changed(s_r.mode_r) && s_r.mode_r == MODE_ACTIVE
        |-> !s_r.ctrl_r[OSC_GATE_BIT] && !s_r.ctrl_r[PLL_GATE_BIT])
        else $error("gating bits survived active entry");
    wake_order_a: assert property (@(posedge CLK) disable iff (!RST_N)
        s_r.seq_r == SEQ_WAKE_OSC && !stab[1] |=> s_r.mode_r != MODE_ACTIVE)
        else $error("active before oscillator stable");
    save_read_a: assert property (@(posedge CLK) disable iff (!RST_N)
        s_r.seq_r == SEQ_ENTER_SAVE |-> !s_r.ctrl_r[SAVE_BIT])
        else $error("save bit set before switch done");
    halt_wait_a: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(s_r.mode_r == MODE_HALT) |-> $past(WAIT_EXEC))
        else $error("halt entered without wait");
    // halt entry: system clock first, oscillator one cycle later
    halt_order_a: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(LOW_OSC_LOWPOWER)
        |-> !SYS_CLK_EN && !SLOW_CLK_EN && (MAIN_OSC_EN == $past(MAIN_OSC_EN)))
        else $error("halt stopped oscillator with system clock");
    wake_osc_a: assert property (@(posedge CLK) disable iff (!RST_N)
        s_r.seq_r == SEQ_WAKE_OSC |-> MAIN_OSC_EN)
        else $error("oscillator not restarted on wake");
    pll_down_a: assert property (@(posedge CLK) disable iff (!RST_N)
        $past(PLL_POWER_DOWN) |-> !PLL_EN)
        else $error("pll running under power-down");
    // gating must not act while the link is awake
    gate_awake_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (s_r.mode_r == MODE_SAVE || s_r.mode_r == MODE_IDLE) && !s_r.ctrl_r[OSC_DIS_BIT]
        && !$past(sleep_now) |-> MAIN_OSC_EN)
        else $error("oscillator gated while link awake");
    enter_save_c: cover property (@(posedge CLK) s_r.seq_r == SEQ_ENTER_SAVE ##[1:20]
        s_r.mode_r == MODE_SAVE);
    enter_halt_c: cover property (@(posedge CLK) s_r.mode_r == MODE_HALT);
    wake_halt_c: cover property (@(posedge CLK) s_r.mode_r == MODE_HALT ##[1:50]
        s_r.mode_r == MODE_ACTIVE);
    gated_sleep_c: cover property (@(posedge CLK) s_r.mode_r == MODE_SAVE && sleep_now
        && !PLL_EN);
endmodule : power_mode_manager
`default_nettype wire

//--- power_link_model.sv
`timescale 1ns/1ps
`default_nettype none
// stand-in for the oscillators, the pll and the radio link controller
module power_link_model
#(
    parameter int SETTLE = 5 // start-up cycles of every clock source
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic osc_en,
    input wire logic pll_en,
    input wire logic sleep_cmd,
    output logic osc_stable,
    output logic pll_stable,
    output logic low_stable,
    output logic link_sleep
);
    int osc_cnt; // cycles since the oscillator was switched on
    int pll_cnt; // the pll only locks while the oscillator runs
    int low_cnt; // slow oscillator start-up after reset
    // sources settle slowly but lose stability at once when switched off
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osc_cnt <= 0;
            pll_cnt <= 0;
            low_cnt <= 0;
            link_sleep <= 1'b0;
        end
        else
        begin
            osc_cnt <= osc_en ? ((osc_cnt < SETTLE) ? osc_cnt + 1 : osc_cnt) : 0;
            pll_cnt <= (pll_en && osc_stable) ? ((pll_cnt < SETTLE) ? pll_cnt + 1 : pll_cnt) : 0;
            low_cnt <= (low_cnt < SETTLE) ? low_cnt + 1 : low_cnt;
            link_sleep <= sleep_cmd;
        end
    end
    assign osc_stable = (osc_cnt >= SETTLE);
    assign pll_stable = (pll_cnt >= SETTLE);
    assign low_stable = (low_cnt >= SETTLE);
endmodule : power_link_model
`default_nettype wire

//--- power_mode_manager_bench.sv
`timescale 1ns/1ps
`default_nettype none
module power_mode_manager_bench;
    import power_mode_pkg::*;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic [23:0] ADDR = 24'h000000;
    logic [7:0] WDATA = 8'h00;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic WAIT_EXEC = 1'b0;
    logic WAKE = 1'b0;
    logic PLL_POWER_DOWN = 1'b0;
    logic sleep_cmd = 1'b0; // link controller asked to sleep
    logic [7:0] RDATA;
    logic LINK_SLEEP, MAIN_OSC_STABLE, PLL_STABLE, LOW_OSC_STABLE;
    logic SYS_CLK_EN, SYS_CLK_SLOW, SLOW_CLK_EN, MAIN_OSC_EN, PLL_EN;
    logic AUX_CLK_EN, LOW_OSC_LOWPOWER;
    logic [1:0] POWER_MODE;
    logic [7:0] v; // last read value
    int fails = 0;
    int n_tests = 0;
    // 50 MHz clock
    always #10 CLK = ~CLK;
    power_mode_manager power_mode_manager_inst (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .WAIT_EXEC(WAIT_EXEC), .WAKE(WAKE),
        .LINK_SLEEP(LINK_SLEEP), .PLL_POWER_DOWN(PLL_POWER_DOWN),
        .MAIN_OSC_STABLE(MAIN_OSC_STABLE), .PLL_STABLE(PLL_STABLE),
        .LOW_OSC_STABLE(LOW_OSC_STABLE), .SYS_CLK_EN(SYS_CLK_EN), .SYS_CLK_SLOW(SYS_CLK_SLOW),
        .SLOW_CLK_EN(SLOW_CLK_EN), .MAIN_OSC_EN(MAIN_OSC_EN), .PLL_EN(PLL_EN),
        .AUX_CLK_EN(AUX_CLK_EN), .LOW_OSC_LOWPOWER(LOW_OSC_LOWPOWER), .POWER_MODE(POWER_MODE));
    power_link_model power_link_model_inst (.clk(CLK), .rst_n(RST_N), .osc_en(MAIN_OSC_EN),
        .pll_en(PLL_EN), .sleep_cmd(sleep_cmd), .osc_stable(MAIN_OSC_STABLE),
        .pll_stable(PLL_STABLE), .low_stable(LOW_OSC_STABLE), .link_sleep(LINK_SLEEP));
    // compare one value and count it
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
    endtask : cyc
    // one-cycle write; entered and left in the time step of a rising edge
    task automatic wr(input logic [23:0] a, input logic [7:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe, so take them mid-cycle
    task automatic rd(input logic [23:0] a);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        @(negedge CLK);
        v = RDATA;
        @(posedge CLK);
    endtask : rd
    // bounded wait for a mode, then judge it
    task automatic wait_mode(input logic [1:0] m);
        // look between edges so a mode launched at this edge is not raced
        @(negedge CLK);
        for (int i = 0; i < 300 && POWER_MODE !== m; i++)
            @(negedge CLK);
        chk({6'h00, POWER_MODE}, {6'h00, m}, "mode");
        cyc(2);
    endtask : wait_mode
    task automatic wait_cmd;
        WAIT_EXEC <= 1'b1;
        @(posedge CLK);
        WAIT_EXEC <= 1'b0;
    endtask : wait_cmd
    // wake is held until active is reached, as a latched wake-up source would
    task automatic wake_up;
        WAKE <= 1'b1;
        wait_mode(2'h0);
        WAKE <= 1'b0;
        cyc(3);
    endtask : wake_up
    task automatic t_reset;
        chk({6'h00, POWER_MODE}, 8'h00, "reset mode");
        rd(MODE_CTRL_ADDR);
        chk(v, 8'h00, "reset ctrl");
        cyc(12);
        wr(CLK_STAT_ADDR, 8'hFF); // read-only place
        rd(CLK_STAT_ADDR);
        chk(v, 8'h07, "status");
        rd(24'hFFFC61); // unmapped
        chk(v, 8'h00, "unmapped");
    endtask : t_reset
    task automatic t_save_now;
        wr(MODE_CTRL_ADDR, 8'h01);
        rd(MODE_CTRL_ADDR);
        chk(v, 8'h00, "save bit early");
        wait_mode(2'h1);
        rd(MODE_CTRL_ADDR);
        chk(v, 8'h01, "save bit set");
        chk({7'h00, SYS_CLK_SLOW}, 8'h01, "slow sysclk");
        wr(MODE_CTRL_ADDR, 8'h00);
        wait_mode(2'h0);
        rd(MODE_CTRL_ADDR);
        chk(v, 8'h00, "save cleared");
    endtask : t_save_now
    task automatic t_save_wait;
        wr(MODE_CTRL_ADDR, 8'h39);
        cyc(4);
        chk({6'h00, POWER_MODE}, 8'h00, "deferred");
        chk({7'h00, MAIN_OSC_EN}, 8'h01, "osc before wait");
        wait_cmd();
        wait_mode(2'h1);
        chk({6'h00, MAIN_OSC_EN, PLL_EN}, 8'h00, "disables");
        chk({7'h00, AUX_CLK_EN}, 8'h00, "aux");
        wake_up();
        rd(MODE_CTRL_ADDR);
        chk(v, 8'h08, "wake clears");
    endtask : t_save_wait
    task automatic t_idle_halt;
        wr(MODE_CTRL_ADDR, 8'h0A);
        wait_cmd();
        wait_mode(2'h2);
        chk({6'h00, SYS_CLK_EN, SLOW_CLK_EN}, 8'h01, "idle clocks");
        wake_up();
        rd(MODE_CTRL_ADDR);
        chk(v, 8'h08, "idle cleared");
        wr(MODE_CTRL_ADDR, 8'h0C);
        wait_cmd();
        wait_mode(2'h3);
        chk({4'h0, SYS_CLK_EN, SLOW_CLK_EN, MAIN_OSC_EN, PLL_EN}, 8'h00, "halt");
        chk({7'h00, LOW_OSC_LOWPOWER}, 8'h01, "low power");
        wake_up();
        chk({7'h00, MAIN_OSC_EN}, 8'h01, "osc back");
        rd(MODE_CTRL_ADDR);
        chk(v, 8'h08, "halt cleared");
    endtask : t_idle_halt
    task automatic t_gating;
        wr(MODE_CTRL_ADDR, 8'hC1);
        wait_mode(2'h1);
        chk({6'h00, MAIN_OSC_EN, PLL_EN}, 8'h03, "awake link");
        PLL_POWER_DOWN <= 1'b1;
        cyc(3);
        chk({7'h00, PLL_EN}, 8'h00, "pll down in save");
        PLL_POWER_DOWN <= 1'b0;
        sleep_cmd <= 1'b1;
        cyc(6);
        chk({6'h00, MAIN_OSC_EN, PLL_EN}, 8'h00, "gated");
        sleep_cmd <= 1'b0;
        wake_up();
        rd(MODE_CTRL_ADDR);
        chk(v, 8'h00, "gates cleared");
        wr(MODE_CTRL_ADDR, 8'hD1);
        wait_mode(2'h1);
        chk({6'h00, MAIN_OSC_EN, PLL_EN}, 8'h01, "disable wins");
        sleep_cmd <= 1'b1;
        cyc(6);
        chk({7'h00, PLL_EN}, 8'h00, "pll gated");
        sleep_cmd <= 1'b0;
        wake_up();
    endtask : t_gating
    task automatic t_active_force;
        wr(MODE_CTRL_ADDR, 8'hF0);
        sleep_cmd <= 1'b1;
        cyc(6);
        chk({6'h00, MAIN_OSC_EN, PLL_EN}, 8'h03, "active on");
        sleep_cmd <= 1'b0;
        PLL_POWER_DOWN <= 1'b1;
        cyc(3);
        chk({6'h00, MAIN_OSC_EN, PLL_EN}, 8'h02, "pll power-down");
        PLL_POWER_DOWN <= 1'b0;
        wr(MODE_CTRL_ADDR, 8'h00);
        cyc(10);
    endtask : t_active_force
    // reset in mid-run must clear a written control register
    task automatic t_reset_mid;
        wr(MODE_CTRL_ADDR, 8'h38);
        rd(MODE_CTRL_ADDR);
        chk(v, 8'h38, "ctrl written");
        RST_N <= 1'b0;
        cyc(2);
        RST_N <= 1'b1;
        @(posedge CLK);
        chk({6'h00, POWER_MODE}, 8'h00, "mid reset mode");
        rd(MODE_CTRL_ADDR);
        chk(v, 8'h00, "mid reset ctrl");
    endtask : t_reset_mid
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    // main sequence: reset for six cycles, then each scenario in turn
    initial
    begin
        repeat (6) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        t_reset();
        t_save_now();
        t_save_wait();
        t_idle_halt();
        t_active_force();
        t_gating();
        t_reset_mid();
        finish_test();
    end
    // a hung wait must not stall the run
    initial
    begin
        #100000;
        fails++;
        finish_test();
    end
endmodule : power_mode_manager_bench
`default_nettype wire
